/* File: spi_eeprom_guard.sv */
`default_nettype none
module spi_eeprom_guard #(
   parameter bit LARGE_DENSITY = 1'b1,
   parameter int PROG_CYCLES = eeprom_guard_pkg::PROG_CYCLES
) (
   // system
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic CLK_EN,
   // spi link, sck is the link clock
   input wire logic SPI_SCK,
   input wire logic SPI_CS_N,
   input wire logic SPI_MOSI,
   output logic SPI_MISO,
   output logic SPI_MISO_OE,
   // write-protect pin
   input wire logic WP_N,
   // status view
   output logic BUSY
);
   localparam int AW = eeprom_guard_pkg::ADDR_W;
   localparam int PW = eeprom_guard_pkg::PAGE_W;
   localparam int BB = eeprom_guard_pkg::BITS_PER_BYTE;
   localparam int DEPTH = LARGE_DENSITY ? 65536 : 32768;

   function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
      return (b & eeprom_guard_pkg::OP_MASK) == op;
   endfunction

   function automatic logic [AW-1:0] fold_addr(input logic [AW-1:0] a);
      return LARGE_DENSITY ? a : (a & eeprom_guard_pkg::ADDR_HALF_LIMIT);
   endfunction

   // array is written in the system domain; program is staged in a page buffer
   logic [7:0] mem [DEPTH];
   logic [7:0] page_buf [eeprom_guard_pkg::PAGE_BYTES];
   logic [eeprom_guard_pkg::PAGE_BYTES-1:0] page_hit;

   // ---------------- link domain ----------------
   logic frame_rst_n;
   assign frame_rst_n = ARST_N & ~SPI_CS_N;
   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   eeprom_guard_pkg::phase_t phase_r;
   logic [7:0] opcode_r;
   logic [AW-1:0] addr_r;
   logic [7:0] tx_r;
   logic tx_en_r;
   logic loaded_r;
   logic busy_l1_r, busy_l2_r;
   logic [7:0] status_l1_r, status_l2_r;
   logic [7:0] status_view;
   logic [7:0] rx_byte;
   assign rx_byte = {shift_r, SPI_MOSI};
   // select high only arms a restart; frame state must outlive the rise for commit
   logic fresh_r;
   logic [2:0] bit_pos;
   assign bit_pos = fresh_r ? 3'h0 : bit_cnt_r;
   logic byte_done;
   assign byte_done = (bit_pos == 3'(BB - 1));

   // status snapshot from system domain, two flops
   always_ff @(posedge SPI_SCK or negedge ARST_N) begin
      if (!ARST_N) begin
         busy_l1_r <= 1'b0;
         busy_l2_r <= 1'b0;
         status_l1_r <= 8'h00;
         status_l2_r <= 8'h00;
      end else begin
         busy_l1_r <= BUSY;
         busy_l2_r <= busy_l1_r;
         status_l1_r <= status_view;
         status_l2_r <= status_l1_r;
      end
   end

   always_ff @(posedge SPI_SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // msb first, restart at select fall
   always_ff @(posedge SPI_SCK or negedge ARST_N) begin
      if (!ARST_N) begin
         bit_cnt_r <= 3'h0;
         shift_r <= 7'h00;
      end else begin
         bit_cnt_r <= bit_pos + 3'h1;
         shift_r <= rx_byte[6:0];
      end
   end

   eeprom_guard_pkg::phase_t op_phase;
   always_comb begin
      op_phase = eeprom_guard_pkg::PH_IGNORE;
      if (op_is(rx_byte, eeprom_guard_pkg::OP_STAT_RD)) begin
         op_phase = eeprom_guard_pkg::PH_STREAM;
      end else if (busy_l2_r) begin
         op_phase = eeprom_guard_pkg::PH_IGNORE;
      end else if (op_is(rx_byte, eeprom_guard_pkg::OP_ARR_RD)
                   || op_is(rx_byte, eeprom_guard_pkg::OP_ARR_WR)) begin
         op_phase = eeprom_guard_pkg::PH_ADDR_HI;
      end else if (op_is(rx_byte, eeprom_guard_pkg::OP_STAT_WR)) begin
         op_phase = eeprom_guard_pkg::PH_STATUS_WR;
      end
   end

   logic is_read, is_write;
   assign is_read = op_is(opcode_r, eeprom_guard_pkg::OP_ARR_RD);
   assign is_write = op_is(opcode_r, eeprom_guard_pkg::OP_ARR_WR);
   logic [AW-1:0] full_addr;
   assign full_addr = fold_addr({addr_r[AW-1:BB], rx_byte});

   always_ff @(posedge SPI_SCK or negedge ARST_N) begin
      if (!ARST_N) begin
         phase_r <= eeprom_guard_pkg::PH_OPCODE;
         opcode_r <= 8'h00;
         addr_r <= '0;
         loaded_r <= 1'b0;
         page_hit <= '0;
      end else if (fresh_r) begin
         phase_r <= eeprom_guard_pkg::PH_OPCODE;
         opcode_r <= 8'h00;
         loaded_r <= 1'b0;
         page_hit <= '0;
      end else if (byte_done) begin
         unique case (phase_r)
            eeprom_guard_pkg::PH_OPCODE: begin
               opcode_r <= rx_byte;
               phase_r <= op_phase;
            end
            eeprom_guard_pkg::PH_ADDR_HI: begin
               addr_r <= {rx_byte, addr_r[BB-1:0]};
               phase_r <= eeprom_guard_pkg::PH_ADDR_LO;
            end
            eeprom_guard_pkg::PH_ADDR_LO: begin
               phase_r <= eeprom_guard_pkg::PH_STREAM;
               addr_r <= is_read ? fold_addr(full_addr + AW'(1)) : full_addr;
            end
            eeprom_guard_pkg::PH_STREAM: begin
               if (is_read) begin
                  addr_r <= fold_addr(addr_r + AW'(1));
               end else if (is_write) begin
                  page_buf[addr_r[PW-1:0]] <= rx_byte;
                  page_hit[addr_r[PW-1:0]] <= 1'b1;
                  addr_r[PW-1:0] <= addr_r[PW-1:0] + PW'(1);
                  loaded_r <= 1'b1;
               end
            end
            eeprom_guard_pkg::PH_STATUS_WR: begin
               opcode_r <= rx_byte;
               loaded_r <= 1'b1;
               phase_r <= eeprom_guard_pkg::PH_IGNORE;
            end
            eeprom_guard_pkg::PH_IGNORE: begin
               phase_r <= eeprom_guard_pkg::PH_IGNORE;
            end
            default: phase_r <= eeprom_guard_pkg::PH_IGNORE;
         endcase
      end
   end

   // read data launched on falling edge, msb first
   logic load_tx;
   assign load_tx = byte_done && (phase_r == eeprom_guard_pkg::PH_ADDR_LO ? is_read
                    : (phase_r == eeprom_guard_pkg::PH_STREAM && !is_write)
                    || (phase_r == eeprom_guard_pkg::PH_OPCODE
                        && op_phase == eeprom_guard_pkg::PH_STREAM));
   logic [7:0] tx_src;
   assign tx_src = (phase_r == eeprom_guard_pkg::PH_OPCODE
                    || op_is(opcode_r, eeprom_guard_pkg::OP_STAT_RD)) ? status_l2_r
                   : (phase_r == eeprom_guard_pkg::PH_ADDR_LO ? mem[full_addr]
                   : mem[addr_r]);
   logic [7:0] tx_next_r;
   logic tx_pend_r;
   always_ff @(posedge SPI_SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_next_r <= 8'h00;
         tx_pend_r <= 1'b0;
      end else begin
         tx_pend_r <= load_tx;
         if (load_tx) begin
            tx_next_r <= tx_src;
         end
      end
   end
   always_ff @(negedge SPI_SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_r <= 8'h00;
         tx_en_r <= 1'b0;
      end else if (tx_pend_r) begin
         tx_r <= tx_next_r;
         tx_en_r <= 1'b1;
      end else begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end
   assign SPI_MISO = tx_r[7];
   assign SPI_MISO_OE = tx_en_r;

   // frame-ready info is stable once select rises; sampled after sync
   logic commit_ok;
   assign commit_ok = loaded_r && (bit_cnt_r == 3'h0);

   // ---------------- system domain ----------------
   logic cs_s1_r, cs_s2_r, cs_s3_r, wp_s1_r, wp_s2_r;
   logic wel_r, busy_r;
   logic [1:0] level_r;
   logic pge_r;
   logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_r;

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
      end else if (CLK_EN) begin
         cs_s1_r <= SPI_CS_N;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         wp_s1_r <= WP_N;
         wp_s2_r <= wp_s1_r;
      end
   end
   logic cs_rise;
   assign cs_rise = cs_s2_r && !cs_s3_r;

   logic hw_guard;
   assign hw_guard = !wp_s2_r && pge_r;

   logic [AW-1:0] prot_base;
   assign prot_base = (level_r == eeprom_guard_pkg::LVL_QUARTER)
      ? (LARGE_DENSITY ? eeprom_guard_pkg::PROT_Q_LARGE : eeprom_guard_pkg::PROT_Q_SMALL)
      : (level_r == eeprom_guard_pkg::LVL_HALF)
      ? (LARGE_DENSITY ? eeprom_guard_pkg::PROT_H_LARGE : eeprom_guard_pkg::PROT_H_SMALL)
      : eeprom_guard_pkg::PROT_ALL;
   logic page_protected;
   assign page_protected = (level_r != eeprom_guard_pkg::LVL_NONE) && (addr_r >= prot_base);

   // link state is frozen while select is high, so reading it here is safe
   logic fr_latch_set, fr_latch_clr, fr_arr_wr, fr_stat_wr;
   assign fr_latch_set = op_is(opcode_r, eeprom_guard_pkg::OP_LATCH_SET)
                         && phase_r == eeprom_guard_pkg::PH_IGNORE;
   assign fr_latch_clr = op_is(opcode_r, eeprom_guard_pkg::OP_LATCH_CLR)
                         && phase_r == eeprom_guard_pkg::PH_IGNORE;
   assign fr_arr_wr = is_write && commit_ok && phase_r == eeprom_guard_pkg::PH_STREAM;
   assign fr_stat_wr = commit_ok && phase_r == eeprom_guard_pkg::PH_IGNORE
                       && !fr_latch_set && !fr_latch_clr;
   logic do_arr, do_stat;
   assign do_arr = cs_rise && !busy_r && wel_r && fr_arr_wr && !page_protected;
   // status write blocked by pin guard
   assign do_stat = cs_rise && !busy_r && wel_r && fr_stat_wr && !hw_guard;
   logic prog_done;
   assign prog_done = busy_r && (prog_cnt_r == '0);

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wel_r <= 1'b0;
         busy_r <= 1'b0;
         level_r <= eeprom_guard_pkg::LVL_NONE;
         pge_r <= 1'b0;
         prog_cnt_r <= '0;
      end else if (CLK_EN) begin
         if (prog_done) begin
            busy_r <= 1'b0;
            wel_r <= 1'b0;
         end else if (do_arr || do_stat) begin
            busy_r <= 1'b1;
            prog_cnt_r <= $bits(prog_cnt_r)'(PROG_CYCLES - 1);
            if (do_stat) begin
               level_r <= {opcode_r[eeprom_guard_pkg::ST_BG_HI],
                           opcode_r[eeprom_guard_pkg::ST_BG_LO]};
               pge_r <= opcode_r[eeprom_guard_pkg::ST_PGE];
            end
         end else if (busy_r) begin
            prog_cnt_r <= prog_cnt_r - 1'b1;
         end else if (cs_rise && fr_latch_set) begin
            wel_r <= 1'b1;
         end else if (cs_rise && fr_latch_clr) begin
            wel_r <= 1'b0;
         end
      end
   end

   // array copy from page buffer at commit; a cycle timer models program
   always_ff @(posedge SYS_CLK) begin
      if (CLK_EN && do_arr) begin
         for (int i = 0; i < eeprom_guard_pkg::PAGE_BYTES; i++) begin
            if (page_hit[i]) begin
               mem[{addr_r[AW-1:PW], PW'(i)}] <= page_buf[i];
            end
         end
      end
   end

   assign status_view = busy_r ? eeprom_guard_pkg::ST_ALL_ONES
      : {pge_r, 3'h0, level_r, wel_r, 1'b0};
   assign BUSY = busy_r;

   // latch drop at end of program
   property p_latch_after_prog;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         (CLK_EN && prog_done) |=> !wel_r && !busy_r;
   endproperty
   a_latch_after_prog: assert property (p_latch_after_prog) else $error("latch kept");

   property p_need_latch;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         (CLK_EN && !busy_r && !wel_r && !$past(busy_r)) |=> !busy_r;
   endproperty
   a_need_latch: assert property (p_need_latch) else $error("program w/o latch");

   property p_guard_status;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         (hw_guard && !busy_r) |=> $stable(level_r) && $stable(pge_r);
   endproperty
   a_guard_status: assert property (p_guard_status) else $error("guarded write");

   property p_pge_sticky;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         (pge_r && !wp_s2_r) |=> pge_r;
   endproperty
   a_pge_sticky: assert property (p_pge_sticky) else $error("enable cleared");

   property p_busy_ones;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         busy_r |-> status_view == eeprom_guard_pkg::ST_ALL_ONES;
   endproperty
   a_busy_ones: assert property (p_busy_ones) else $error("busy status");

   property p_idle_zero;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         !busy_r |-> status_view[6:4] == 3'h0 && !status_view[eeprom_guard_pkg::ST_BUSY];
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("idle bits");

   property p_prog_len;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         $rose(busy_r) && CLK_EN |=> busy_r [*8];
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("short cycle");

   property p_wel_view;
      @(posedge SYS_CLK) disable iff (!ARST_N)
         !busy_r |-> status_view[eeprom_guard_pkg::ST_WEL] == wel_r;
   endproperty
   a_wel_view: assert property (p_wel_view) else $error("latch view");
endmodule // spi_eeprom_guard
`default_nettype wire

/* File: eeprom_guard_pkg.sv */
`default_nettype none
package eeprom_guard_pkg;
   // opcodes: upper nibble zero, bit 3 ignored
   localparam logic [7:0] OP_MASK = 8'hF7;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_ARR_RD = 8'h03;
   localparam logic [7:0] OP_ARR_WR = 8'h02;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_BG_LO = 2;
   localparam int ST_BG_HI = 3;
   localparam int ST_PGE = 7;
   localparam logic [7:0] ST_ALL_ONES = 8'hFF;
   localparam logic [7:0] ST_WR_MASK = 8'h8C;
   // array and page geometry
   localparam int ADDR_W = 16;
   localparam int PAGE_W = 7;
   localparam int PAGE_BYTES = 128;
   localparam logic [ADDR_W-1:0] ADDR_FULL_LIMIT = 16'hFFFF;
   localparam logic [ADDR_W-1:0] ADDR_HALF_LIMIT = 16'h7FFF;
   // protect boundaries, large then small density
   localparam logic [ADDR_W-1:0] PROT_Q_LARGE = 16'hC000;
   localparam logic [ADDR_W-1:0] PROT_H_LARGE = 16'h8000;
   localparam logic [ADDR_W-1:0] PROT_Q_SMALL = 16'h6000;
   localparam logic [ADDR_W-1:0] PROT_H_SMALL = 16'h4000;
   localparam logic [ADDR_W-1:0] PROT_ALL = 16'h0000;
   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_QUARTER = 2'h1;
   localparam logic [1:0] LVL_HALF = 2'h2;
   // program cycle time
   localparam longint PROG_TIME_NS = 10000000;
   localparam longint CLK_PERIOD_NS = 10;
   localparam int PROG_CYCLES = int'(PROG_TIME_NS / CLK_PERIOD_NS);
   localparam int BITS_PER_BYTE = 8;
   typedef enum logic [2:0] {
      PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_STREAM, PH_STATUS_WR, PH_IGNORE
   } phase_t;
endpackage : eeprom_guard_pkg
`default_nettype wire

/* File: spi_master_model.sv */
`default_nettype none
module spi_master_model (
   // spi link
   output logic SPI_SCK,
   output logic SPI_CS_N,
   output logic SPI_MOSI,
   input wire logic SPI_MISO,
   input wire logic SPI_MISO_OE
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 32;
   logic seen_r;

   initial begin
      SPI_SCK = 1'b0;
      SPI_CS_N = 1'b1;
      SPI_MOSI = 1'b0;
      seen_r = 1'b0;
   end

   task automatic sel();
      #3;
      SPI_CS_N = 1'b0;
      #(HALF);
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         SPI_MOSI = tx[i];
         #(HALF);
         SPI_SCK = 1'b1;
         // undriven line must not look like valid data
         seen_r = SPI_MISO_OE ? SPI_MISO : ~seen_r;
         rx[i] = seen_r;
         #(HALF);
         SPI_SCK = 1'b0;
      end
   endtask

   // select rises in low phase after last bit
   task automatic desel();
      #16;
      SPI_CS_N = 1'b1;
      SPI_MOSI = ~SPI_MOSI;
      // gap longer than four system cycles
      #120;
   endtask
endmodule // spi_master_model
`default_nettype wire

/* File: spi_eeprom_guard_tb.sv */
`default_nettype none
module spi_eeprom_guard_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // short program cycle so a status read fits inside it
   localparam int PROG = 400;
   logic sys_clk, arst_n, clk_en, wp_n, busy;
   wire sck, cs_n, mosi, miso, miso_oe;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [7:0] rd_buf [128];
   logic [7:0] exp_pg [128];

   spi_eeprom_guard #(.LARGE_DENSITY(1'b1), .PROG_CYCLES(PROG)) u_dut (
      .SYS_CLK(sys_clk), .ARST_N(arst_n), .CLK_EN(clk_en),
      .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
      .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .WP_N(wp_n), .BUSY(busy));
   spi_master_model u_master (.SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
      .SPI_MISO(miso), .SPI_MISO_OE(miso_oe));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check8(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      logic [7:0] rx;
      u_master.sel();
      u_master.xfer(op, rx);
      u_master.desel();
   endtask

   task automatic frame2(input logic [7:0] op, input logic [7:0] v, output logic [7:0] st);
      u_master.sel();
      u_master.xfer(op, st);
      u_master.xfer(v, st);
      u_master.desel();
   endtask

   task automatic page_wr(input logic [15:0] a, input logic [7:0] seed, input int n);
      logic [7:0] rx;
      u_master.sel();
      u_master.xfer(eeprom_guard_pkg::OP_ARR_WR, rx);
      u_master.xfer(a[15:8], rx);
      u_master.xfer(a[7:0], rx);
      for (int i = 0; i < n; i++) u_master.xfer(seed + 8'(i), rx);
      u_master.desel();
   endtask

   task automatic rd(input logic [15:0] a, input int n);
      logic [7:0] rx;
      u_master.sel();
      u_master.xfer(eeprom_guard_pkg::OP_ARR_RD, rx);
      u_master.xfer(a[15:8], rx);
      u_master.xfer(a[7:0], rx);
      for (int i = 0; i < n; i++) u_master.xfer(8'hFF, rd_buf[i]);
      u_master.desel();
   endtask

   task automatic stat(output logic [7:0] st);
      frame2(eeprom_guard_pkg::OP_STAT_RD, 8'h00, st);
   endtask

   task automatic wait_idle();
      repeat (4) @(negedge sys_clk);
      for (int i = 0; i < PROG + 50 && busy === 1'b1; i++) @(negedge sys_clk);
      check8({7'h00, busy}, 8'h00);
   endtask

   task automatic t_reset();
      logic [7:0] st;
      stat(st);
      check8(st & 8'h73, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_latch();
      logic [7:0] st;
      logic [7:0] ops [4];
      ops = '{8'h06, 8'h04, 8'h0E, 8'h0C};
      for (int k = 0; k < 4; k++) begin
         cmd(ops[k]);
         stat(st);
         check8(st & 8'h73, k[0] ? 8'h00 : 8'h02);
      end
      $display("test latch done");
   endtask

   task automatic t_nolatch();
      page_wr(16'h0000, 8'h33, 128);
      repeat (4) @(negedge sys_clk);
      check8({7'h00, busy}, 8'h00);
      $display("test nolatch done");
   endtask

   task automatic t_page();
      logic [7:0] st;
      cmd(eeprom_guard_pkg::OP_LATCH_SET);
      page_wr(16'h007E, 8'h10, 130);
      repeat (4) @(negedge sys_clk);
      check8({7'h00, busy}, 8'h01);
      stat(st);
      check8(st, 8'hFF);
      // must be discarded while busy
      cmd(eeprom_guard_pkg::OP_LATCH_SET);
      wait_idle();
      stat(st);
      check8(st & 8'h73, 8'h00);
      for (int i = 0; i < 130; i++) exp_pg[(i + 126) % 128] = 8'h10 + 8'(i);
      rd(16'h0000, 128);
      for (int i = 0; i < 128; i++) check8(rd_buf[i], exp_pg[i]);
      rd(16'hFFFF, 2);
      check8(rd_buf[1], exp_pg[0]);
      $display("test page done");
   endtask

   task automatic t_guard();
      logic [7:0] st;
      cmd(eeprom_guard_pkg::OP_LATCH_SET);
      frame2(eeprom_guard_pkg::OP_STAT_WR, 8'h8C, st);
      wait_idle();
      stat(st);
      check8(st, 8'h8C);
      cmd(eeprom_guard_pkg::OP_LATCH_SET);
      page_wr(16'h0000, 8'h55, 128);
      wait_idle();
      rd(16'h0000, 1);
      check8(rd_buf[0], exp_pg[0]);
      @(negedge sys_clk) wp_n = 1'b0;
      cmd(eeprom_guard_pkg::OP_LATCH_SET);
      frame2(eeprom_guard_pkg::OP_STAT_WR, 8'h00, st);
      wait_idle();
      stat(st);
      check8(st, 8'h8E);
      @(negedge sys_clk) wp_n = 1'b1;
      frame2(eeprom_guard_pkg::OP_STAT_WR, 8'h00, st);
      wait_idle();
      stat(st);
      check8(st, 8'h00);
      $display("test guard done");
   endtask

   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      wp_n = 1'b1;
      repeat (12) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      t_reset();
      t_latch();
      t_nolatch();
      t_page();
      t_guard();
      finish_test();
   end

   // whole run is near 310 us; allow about three times that
   initial begin
      #900000;
      n_mismatch++;
      finish_test();
   end
endmodule // spi_eeprom_guard_tb
`default_nettype wire
